// ---- timer_defines.svh ----
// Purpose: Constants for the dual 8-bit timer/event counter.
// Assumes: Byte-wide CPU register port, main clock 20 MHz.
// Notes:   Definitions only.
//
// Function
// RL1: The counter is an 8-bit up-counter, read-only to software, that steps on each selected count clock.
// RL2: The counter is forced to 00H on reset, when counting is disabled, and on a match in match-clear mode.
// RL3: Outside PWM mode a counter/compare match raises the timer interrupt request.
// RL4: In PWM mode the output goes active on counter overflow and inactive on compare match.
// RL5: The compare register is a read/write byte taking 00H to FFH and resets to 00H.
// RL6: Software does not change the compare value while counting in match-clear mode.
// RL7: In PWM mode software leaves at least three count clocks between compare writes.
// RL8: Instance 0 codes select event falling, rising, then fx/2, /4, /16, /64, /256, /8192.
// RL9: Instance 1 codes select event falling, rising, fx/2, /32, /128, /1024, /8192, then internal oscillator/128.
// RL10: Software writes zero to clock-select bits 3 to 7; only bits 0 to 2 select the clock.
// RL11: Software stops the timer before changing the clock select.
// RL12: Reset clears both clock-select registers to 00H, the event-pin falling edge.
// RL13: Software keeps the selected count clock at or below 10 MHz.
// RL14: Writing the count-enable bit to 1 starts counting; writing 0 clears and stops the counter.
// RL15: The mode-select bit chooses match-clear (0) or free-running PWM (1).
// RL16: The event pin is synchronised and each selected edge yields one single-cycle count pulse.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define CLK_SEL0_ADDR  16'hFF2E
`define MODE0_ADDR     16'hFF2F
`define CNT0_ADDR      16'hFF20
`define CMP0_ADDR      16'hFF21
`define CLK_SEL1_ADDR  16'hFF3E
`define MODE1_ADDR     16'hFF3F
`define CNT1_ADDR      16'hFF30
`define CMP1_ADDR      16'hFF31

`define REG_RST        8'h00
`define CNT_MAX        8'hFF
`define SEL_W          3

`define MODE_TCE_BIT   7
`define MODE_PWM_BIT   6
`define MODE_LVS_BIT   3
`define MODE_LVR_BIT   2
`define MODE_LVL_BIT   1
`define MODE_TOE_BIT   0

`define PRESC_W        13
`define FR_DIV_W       7

`endif

// ---- timer_pkg.sv ----
// Purpose: Shared types of the dual timer.
// Assumes: Nothing beyond the defines header.
// Notes:   Clock-select codes are common to both instances.
package timer_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [15:0] addr_t;
	typedef enum logic [2:0] {
		SEL_EV_FALL = 3'h0,
		SEL_EV_RISE = 3'h1,
		SEL_DIV_A   = 3'h2,
		SEL_DIV_B   = 3'h3,
		SEL_DIV_C   = 3'h4,
		SEL_DIV_D   = 3'h5,
		SEL_DIV_E   = 3'h6,
		SEL_DIV_F   = 3'h7
	} clk_sel_t;
endpackage : timer_pkg

// ---- channel_if.sv ----
// Purpose: Control and status between the register block and one channel.
// Assumes: Single clock domain.
// Notes:   lvs and lvr are one-cycle write pulses.
`timescale 1ns/1ps
`default_nettype none
interface channel_if;
	logic              tick;
	logic              tce;
	logic              pwm;
	logic              lvl;
	logic              toe;
	logic              lvs;
	logic              lvr;
	timer_pkg::byte_t  cmp;
	timer_pkg::byte_t  cnt;
	logic              irq;
	logic              pin;
	modport chan (input tick, tce, pwm, lvl, toe, lvs, lvr, cmp,
		output cnt, irq, pin);
	modport ctrl (output tick, tce, pwm, lvl, toe, lvs, lvr, cmp,
		input cnt, irq, pin);
endinterface : channel_if
`default_nettype wire

// ---- count_channel.sv ----
// Purpose: One 8-bit counter with compare, interval and PWM output.
// Assumes: tick is a one-cycle pulse per count clock.
// Notes:   Output pin is registered.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module count_channel (
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_arst_n,
	// Control from the register block
	channel_if.chan   ch
);
	import timer_pkg::*;

	byte_t cnt_q;
	byte_t cnt_d;
	byte_t cnt_inc;
	logic  irq_q;
	logic  irq_d;
	logic  tff_q;
	logic  tff_d;
	logic  pwm_q;
	logic  pwm_d;
	logic  pin_q;
	logic  pin_d;

	always_comb begin
		cnt_d   = cnt_q;
		irq_d   = 1'b0;
		tff_d   = tff_q;
		pwm_d   = pwm_q;
		cnt_inc = cnt_q + 8'h01;
		if (!ch.tce) begin
			cnt_d = `REG_RST; // RL2 RL14
			pwm_d = 1'b0;
		end else if (ch.tick) begin
			if (ch.pwm) begin // RL15
				cnt_d = cnt_inc; // RL1
				if (cnt_q == `CNT_MAX) begin
					pwm_d = 1'b1; // RL4
				end else if (cnt_inc == ch.cmp) begin
					pwm_d = 1'b0; // RL4
				end
			end else if (cnt_q == ch.cmp) begin
				cnt_d = `REG_RST; // RL2
				irq_d = 1'b1; // RL3
				if (ch.lvl) begin
					tff_d = ~tff_q;
				end
			end else begin
				cnt_d = cnt_inc; // RL1
			end
		end
		// Level set/reset only acts outside PWM
		if (!ch.pwm) begin
			if (ch.lvs) begin
				tff_d = 1'b1;
			end else if (ch.lvr) begin
				tff_d = 1'b0;
			end
		end
		pin_d = ch.toe & (ch.pwm ? (pwm_q ^ ch.lvl) : tff_q);
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q <= `REG_RST;
			irq_q <= 1'b0;
			tff_q <= 1'b0;
			pwm_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			irq_q <= irq_d;
			tff_q <= tff_d;
			pwm_q <= pwm_d;
			pin_q <= pin_d;
		end
	end

	assign ch.cnt = cnt_q;
	assign ch.irq = irq_q;
	assign ch.pin = pin_q;
endmodule : count_channel
`default_nettype wire

// ---- event_timer_top.sv ----
// Purpose: Two 8-bit timer/event counters behind a byte register port.
// Assumes: i_ref_clk is the main oscillator clock fx at 20 MHz.
// Notes:   Event and internal-oscillator pins are asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module event_timer_top (
	// Clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_arst_n,
	// CPU register port
	input  wire timer_pkg::addr_t  i_addr,
	input  wire timer_pkg::byte_t  i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output var  timer_pkg::byte_t  o_rdata,
	// Pins
	input  wire logic [1:0]        i_event_input_pin,
	input  wire logic              i_internal_osc_clock,
	output var  logic [1:0]        o_timer_output_pin,
	output var  logic [1:0]        o_timer_irq
);
	import timer_pkg::*;

	localparam int NCH = 2;
	localparam addr_t SEL_ADDR [NCH] = '{`CLK_SEL0_ADDR, `CLK_SEL1_ADDR};
	localparam addr_t MODE_ADDR[NCH] = '{`MODE0_ADDR, `MODE1_ADDR};
	localparam addr_t CNT_ADDR [NCH] = '{`CNT0_ADDR, `CNT1_ADDR};
	localparam addr_t CMP_ADDR [NCH] = '{`CMP0_ADDR, `CMP1_ADDR};

	// True when the prescaler has just completed a 2^k period
	function automatic logic div_hit(
		input logic [`PRESC_W-1:0] presc,
		input int                  k
	);
		logic [`PRESC_W-1:0] mask;
		mask = (`PRESC_W'(1) << k) - `PRESC_W'(1);
		return (presc & mask) == mask;
	endfunction : div_hit

	// Count-pulse decode per instance
	function automatic logic sel_tick(
		input int                  inst,
		input clk_sel_t            code,
		input logic                fall,
		input logic                rise,
		input logic [`PRESC_W-1:0] presc,
		input logic                fr_tick
	);
		logic t;
		t = 1'b0;
		case (code)
			SEL_EV_FALL: t = fall;
			SEL_EV_RISE: t = rise;
			SEL_DIV_A:   t = div_hit(presc, 1);
			SEL_DIV_B:   t = (inst == 0) ? div_hit(presc, 2)
				: div_hit(presc, 5);
			SEL_DIV_C:   t = (inst == 0) ? div_hit(presc, 4)
				: div_hit(presc, 7);
			SEL_DIV_D:   t = (inst == 0) ? div_hit(presc, 6)
				: div_hit(presc, 10);
			SEL_DIV_E:   t = (inst == 0) ? div_hit(presc, 8)
				: div_hit(presc, 13);
			SEL_DIV_F:   t = (inst == 0) ? div_hit(presc, 13) : fr_tick;
			default:     t = 1'b0;
		endcase
		return t;
	endfunction : sel_tick

	// Free-running fx prescaler
	logic [`PRESC_W-1:0] presc_q;
	logic [`PRESC_W-1:0] presc_d;

	always_comb begin
		presc_d = presc_q + `PRESC_W'(1);
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_d;
		end
	end

	// Internal oscillator: synchronise, then divide its rising edges by 128
	logic [2:0]           fr_sync_q;
	logic [2:0]           fr_sync_d;
	logic                 fr_lvl_q;
	logic                 fr_lvl_d;
	logic [`FR_DIV_W-1:0] fr_cnt_q;
	logic [`FR_DIV_W-1:0] fr_cnt_d;
	logic                 fr_tick;

	always_comb begin
		fr_sync_d = {fr_sync_q[1:0], i_internal_osc_clock};
		fr_lvl_d  = fr_lvl_q;
		fr_cnt_d  = fr_cnt_q;
		fr_tick   = 1'b0;
		if (fr_sync_q[1] == fr_sync_q[2] && fr_sync_q[2] != fr_lvl_q) begin
			fr_lvl_d = fr_sync_q[2];
			if (fr_sync_q[2]) begin
				fr_cnt_d = fr_cnt_q + `FR_DIV_W'(1);
				fr_tick  = &fr_cnt_q;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fr_sync_q <= '0;
			fr_lvl_q  <= 1'b0;
			fr_cnt_q  <= '0;
		end else begin
			fr_sync_q <= fr_sync_d;
			fr_lvl_q  <= fr_lvl_d;
			fr_cnt_q  <= fr_cnt_d;
		end
	end

	// Per-channel registers, event sync and counter
	byte_t      cnt_rd [NCH];
	byte_t      sel_rd [NCH];
	byte_t      mode_rd[NCH];
	byte_t      cmp_rd [NCH];

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			channel_if ch ();

			logic [`SEL_W-1:0] sel_q;
			logic [`SEL_W-1:0] sel_d;
			byte_t             mode_q;
			byte_t             mode_d;
			byte_t             cmp_q;
			byte_t             cmp_d;
			logic [2:0]        ev_sync_q;
			logic [2:0]        ev_sync_d;
			logic              ev_lvl_q;
			logic              ev_lvl_d;
			logic              ev_fall;
			logic              ev_rise;
			logic              mode_wr;

			// Select keeps only bits 0 to 2; its upper bits read as zero
			always_comb begin
				mode_wr = i_wr && (i_addr == MODE_ADDR[g]);
				sel_d   = sel_q;
				mode_d  = mode_q;
				cmp_d   = cmp_q;
				if (i_wr && (i_addr == SEL_ADDR[g])) begin
					sel_d = i_wdata[`SEL_W-1:0]; // RL10
				end
				if (mode_wr) begin
					// Set/reset bits are strobes, never stored
					mode_d = i_wdata & ~((8'h01 << `MODE_LVS_BIT)
						| (8'h01 << `MODE_LVR_BIT));
				end
				if (i_wr && (i_addr == CMP_ADDR[g])) begin
					cmp_d = i_wdata; // RL5
				end
			end

			always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					sel_q  <= `SEL_W'(`REG_RST); // RL12
					mode_q <= `REG_RST;
					cmp_q  <= `REG_RST; // RL5
				end else begin
					sel_q  <= sel_d;
					mode_q <= mode_d;
					cmp_q  <= cmp_d;
				end
			end

			// Edge counts once the second and third stages agree
			always_comb begin
				ev_sync_d = {ev_sync_q[1:0], i_event_input_pin[g]};
				ev_lvl_d  = ev_lvl_q;
				ev_fall   = 1'b0;
				ev_rise   = 1'b0;
				if (ev_sync_q[1] == ev_sync_q[2]
					&& ev_sync_q[2] != ev_lvl_q) begin
					ev_lvl_d = ev_sync_q[2];
					ev_rise  = ev_sync_q[2]; // RL16
					ev_fall  = ~ev_sync_q[2]; // RL16
				end
			end

			// Level starts low, so a high pin after reset gives one rise
			always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					ev_sync_q <= '0;
					ev_lvl_q  <= 1'b0;
				end else begin
					ev_sync_q <= ev_sync_d;
					ev_lvl_q  <= ev_lvl_d;
				end
			end

			assign ch.tick = sel_tick(g, clk_sel_t'(sel_q), ev_fall, ev_rise,
				presc_q, fr_tick); // RL8 RL9
			assign ch.tce  = mode_q[`MODE_TCE_BIT]; // RL14
			assign ch.pwm  = mode_q[`MODE_PWM_BIT]; // RL15
			assign ch.lvl  = mode_q[`MODE_LVL_BIT];
			assign ch.toe  = mode_q[`MODE_TOE_BIT];
			assign ch.lvs  = mode_wr && i_wdata[`MODE_LVS_BIT]
				&& !i_wdata[`MODE_LVR_BIT];
			assign ch.lvr  = mode_wr && i_wdata[`MODE_LVR_BIT]
				&& !i_wdata[`MODE_LVS_BIT];
			assign ch.cmp  = cmp_q;

			count_channel u_chan (
				.i_ref_clk (i_ref_clk),
				.i_arst_n  (i_arst_n),
				.ch        (ch.chan)
			);

			assign cnt_rd[g]             = ch.cnt; // RL1
			assign sel_rd[g]             = {5'h00, sel_q};
			assign mode_rd[g]            = mode_q;
			assign cmp_rd[g]             = cmp_q;
			assign o_timer_output_pin[g] = ch.pin;
			assign o_timer_irq[g]        = ch.irq;
		end
	endgenerate

	// Registered read data; unmapped addresses read 00H
	byte_t rdata_q;
	byte_t rdata_d;

	always_comb begin
		rdata_d = rdata_q;
		if (i_rd) begin
			rdata_d = `REG_RST;
			for (int i = 0; i < NCH; i++) begin
				if (i_addr == SEL_ADDR[i]) begin
					rdata_d = sel_rd[i];
				end
				if (i_addr == MODE_ADDR[i]) begin
					rdata_d = mode_rd[i];
				end
				if (i_addr == CNT_ADDR[i]) begin
					rdata_d = cnt_rd[i];
				end
				if (i_addr == CMP_ADDR[i]) begin
					rdata_d = cmp_rd[i];
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_q <= `REG_RST;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;
endmodule : event_timer_top
`default_nettype wire

// ---- event_timer_monitor.sv ----
// Purpose: Port-level checks of the dual timer.
// Assumes: Mode, compare and select of instance 0 tracked from writes.
// Notes:   Most checks watch instance 0.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module event_timer_monitor (
	// Watched ports of the timer top
	input wire logic             i_ref_clk,
	input wire logic             i_arst_n,
	input wire timer_pkg::addr_t i_addr,
	input wire timer_pkg::byte_t i_wdata,
	input wire logic             i_wr,
	input wire logic             i_rd,
	input wire timer_pkg::byte_t o_rdata,
	input wire logic [1:0]       i_event_input_pin,
	input wire logic             i_internal_osc_clock,
	input wire logic [1:0]       o_timer_output_pin,
	input wire logic [1:0]       o_timer_irq
);
	import timer_pkg::*;
	byte_t      mode_q, mode_d, cmp_q, cmp_d;
	logic [2:0] sel_q, sel_d;
	always_comb begin
		mode_d = mode_q;
		cmp_d = cmp_q;
		sel_d = sel_q;
		if (i_wr && i_addr == `MODE0_ADDR) mode_d = i_wdata;
		if (i_wr && i_addr == `CMP0_ADDR) cmp_d = i_wdata;
		if (i_wr && i_addr == `CLK_SEL0_ADDR) sel_d = i_wdata[2:0];
	end
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_q <= 8'h00;
			cmp_q <= 8'h00;
			sel_q <= 3'h0;
		end else begin
			mode_q <= mode_d;
			cmp_q <= cmp_d;
			sel_q <= sel_d;
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	a_reset_quiet: assert property ($rose(i_arst_n) |-> !o_rdata && !o_timer_irq)
		else $error("not clear after reset");
	a_irq0_pulse: assert property (o_timer_irq[0] |=> !o_timer_irq[0])
		else $error("irq0 too long");
	a_irq1_pulse: assert property (o_timer_irq[1] |=> !o_timer_irq[1])
		else $error("irq1 too long");
	a_cmp_readback: assert property (i_rd && i_addr == `CMP0_ADDR
		|=> o_rdata == $past(cmp_q)) else $error("compare readback");
	a_sel_readback: assert property (i_rd && i_addr == `CLK_SEL0_ADDR
		|=> o_rdata == {5'h00, $past(sel_q)}) else $error("select readback");
	// Counter clears one edge after the enable drops
	a_stop_clears: assert property (i_rd && i_addr == `CNT0_ADDR
		&& !mode_q[7] && !$past(mode_q[7]) |=> o_rdata == 8'h00)
		else $error("stopped counter not zero");
	a_stop_quiet: assert property (!mode_q[7] && !$past(mode_q[7])
		|-> !o_timer_irq[0]) else $error("irq while stopped");
	a_pwm_no_irq: assert property (mode_q[6] && $past(mode_q[6])
		|-> !o_timer_irq[0]) else $error("irq in pwm mode");
	a_out_disabled: assert property ((!mode_q[0])[*3]
		|-> !o_timer_output_pin[0]) else $error("output not low");
	c_irq0: cover property (o_timer_irq[0]);
	c_irq1: cover property (o_timer_irq[1]);
	c_pwm: cover property (mode_q[6] && $rose(o_timer_output_pin[0]));
endmodule : event_timer_monitor
`default_nettype wire

// ---- pin_model.sv ----
// Purpose: Far-side pins: event sources and internal oscillator.
// Assumes: Event pins idle low; oscillator runs free.
// Notes:   Oscillator far faster than real to keep runs short.
`timescale 1ns/1ps
`default_nettype none
module pin_model #(
	parameter int FR_HALF_NS = 200
) (
	// Pins into the timer
	output var logic [1:0] o_event,
	output var logic       o_fr
);
	initial begin
		o_event = 2'h0;
		o_fr = 1'b0;
		#13;
		forever #(FR_HALF_NS) o_fr = ~o_fr;
	end
	// Eight main clocks per level keeps events far below 10 MHz
	task automatic pulse(int i);
		o_event[i] = 1'b1;
		#400;
		o_event[i] = 1'b0;
		#400;
	endtask : pulse
endmodule : pin_model
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the dual timer.
// Assumes: Pin model drives event pins and internal oscillator.
// Notes:   Interval rows, then events, PWM and a mid-run reset.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import timer_pkg::*;
	typedef struct {int i; logic [2:0] code; byte_t cmp; int div;} row_t;
	logic       i_ref_clk, i_arst_n, i_wr, i_rd, fr;
	addr_t      i_addr;
	byte_t      i_wdata, o_rdata;
	logic [1:0] ev, o_timer_output_pin, o_timer_irq;
	int         bad_count, compares, cyc, n, k;
	logic [3:0] offs[4] = '{4'hE, 4'h1, 4'h0, 4'hF};
	// Last row: 128 oscillator periods of eight main clocks
	row_t rows[12] = '{'{0,3'h2,8'h03,2}, '{0,3'h3,8'h01,4},
		'{0,3'h4,8'h01,16}, '{0,3'h5,8'h00,64}, '{0,3'h6,8'h00,256},
		'{0,3'h7,8'h00,8192}, '{1,3'h2,8'h02,2}, '{1,3'h3,8'h01,32},
		'{1,3'h4,8'h00,128}, '{1,3'h5,8'h00,1024},
		'{1,3'h6,8'h00,8192}, '{1,3'h7,8'h00,1024}};
	event_timer_top DUT (.i_ref_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr,
		.i_rd, .o_rdata, .i_event_input_pin(ev), .i_internal_osc_clock(fr),
		.o_timer_output_pin, .o_timer_irq);
	pin_model pins (.o_event(ev), .o_fr(fr));
	function automatic addr_t ad(int i, logic [3:0] o);
		return {8'hFF, 4'(2 + i), o};
	endfunction : ad
	task automatic stop_test();
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(addr_t a, byte_t d);
		@(posedge i_ref_clk);
		#2;
		i_addr = a;
		i_wdata = d;
		i_wr = 1'b1;
		@(posedge i_ref_clk);
		#2;
		i_wr = 1'b0;
	endtask : wr
	task automatic rd(addr_t a, byte_t e);
		@(posedge i_ref_clk);
		#2;
		i_addr = a;
		i_rd = 1'b1;
		@(posedge i_ref_clk);
		#2;
		i_rd = 1'b0;
		chk({8'h00, o_rdata}, {8'h00, e});
	endtask : rd
	task automatic wirq(int i);
		n = 0;
		do begin
			@(posedge i_ref_clk);
			#2;
			n++;
		end while (o_timer_irq[i] !== 1'b1 && n < 20000);
	endtask : wirq
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 80000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		{i_arst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
		repeat (10) @(posedge i_ref_clk);
		#2;
		i_arst_n = 1'b1;
		foreach (rows[r]) begin
			wr(ad(rows[r].i, 4'hF), 8'h00);
			wr(ad(rows[r].i, 4'hE), {5'h00, rows[r].code});
			wr(ad(rows[r].i, 4'h1), rows[r].cmp);
			wr(ad(rows[r].i, 4'hF), 8'h80);
			wirq(rows[r].i);
			wirq(rows[r].i);
			chk(16'(n), 16'((rows[r].cmp + 1) * rows[r].div));
			wr(ad(rows[r].i, 4'hF), 8'h00);
		end
		for (int i = 0; i < 2; i++) begin
			wr(ad(i, 4'hE), 8'hF8 | 8'(i));
			rd(ad(i, 4'hE), 8'(i));
			wr(ad(i, 4'h1), 8'h0A);
			wr(ad(i, 4'hF), 8'h80);
			repeat (3) pins.pulse(i);
			wr(ad(i, 4'h0), 8'h55);
			rd(ad(i, 4'h0), 8'h03);
			wr(ad(i, 4'hF), 8'h00);
			rd(ad(i, 4'h0), 8'h00);
		end
		// Output flip-flop of instance 1: set, reset, then toggle on match
		wr(ad(1, 4'hE), 8'h02);
		wr(ad(1, 4'h1), 8'h02);
		for (int s = 0; s < 2; s++) begin
			wr(ad(1, 4'hF), (s == 0) ? 8'h09 : 8'h05);
			@(posedge i_ref_clk);
			#2;
			chk(16'(o_timer_output_pin[1]), 16'(s == 0));
		end
		wr(ad(1, 4'hF), 8'h83);
		for (int s = 0; s < 2; s++) begin
			wirq(1);
			@(posedge i_ref_clk);
			#2;
			chk(16'(o_timer_output_pin[1]), 16'(s == 0));
		end
		wr(ad(1, 4'hF), 8'h00);
		wr(ad(0, 4'hE), 8'h02);
		wr(ad(0, 4'h1), 8'h40);
		for (int l = 0; l < 2; l++) begin
			wr(ad(0, 4'hF), 8'hC1 | 8'(l << 1));
			repeat (600) @(posedge i_ref_clk);
			k = 0;
			repeat (512) begin
				@(posedge i_ref_clk);
				k += int'(o_timer_output_pin[0] === (l == 0));
			end
			chk(16'(k), 16'h0080);
			wr(ad(0, 4'hF), 8'h00);
		end
		wr(ad(0, 4'hF), 8'h80);
		i_arst_n = 1'b0;
		repeat (10) @(posedge i_ref_clk);
		#2;
		i_arst_n = 1'b1;
		for (int i = 0; i < 2; i++)
			foreach (offs[j]) rd(ad(i, offs[j]), 8'h00);
		stop_test();
	end
endmodule : tb_top
bind event_timer_top event_timer_monitor mon (.i_ref_clk, .i_arst_n,
	.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_event_input_pin,
	.i_internal_osc_clock, .o_timer_output_pin, .o_timer_irq);
`default_nettype wire
